// File: src/branch_ccr_decoder.sv
`timescale 1ns/10ps
module branch_ccr_decoder (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_valid,
	input wire branch_ccr_pkg::dec_req_s i_req,
	output logic o_ready,
	output logic o_done,
	output branch_ccr_pkg::dec_rsp_s o_rsp,
	output logic [5:0] o_flags
);

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} state_e;

	state_e state_reg;
	logic [3:0] count_reg;
	logic [5:0] flags_reg;
	branch_ccr_pkg::dec_rsp_s rsp_reg;
	branch_ccr_pkg::dec_rsp_s dec;
	logic [5:0] flags_next;
	logic n, z, v, c, nxv;

	assign n = flags_reg[branch_ccr_pkg::FLAG_N];
	assign z = flags_reg[branch_ccr_pkg::FLAG_Z];
	assign v = flags_reg[branch_ccr_pkg::FLAG_V];
	assign c = flags_reg[branch_ccr_pkg::FLAG_C];
	assign nxv = n ^ v;

	always_comb begin
		dec = '0;
		dec.kind = branch_ccr_pkg::KIND_NONE;
		dec.legal = 1'b1;
		dec.cycles = branch_ccr_pkg::CYC_SHORT;
		dec.length = branch_ccr_pkg::LEN_ONE;
		dec.acc_data = i_req.acc_a;
		flags_next = flags_reg;
		if (i_req.opcode[7:4] == 4'h2) begin
			dec.kind = branch_ccr_pkg::KIND_BRANCH;
			dec.cycles = branch_ccr_pkg::CYC_BRANCH;
			dec.length = branch_ccr_pkg::LEN_TWO;
			dec.target = i_req.pc + 16'h0002 +
				{{8{i_req.offset[7]}}, i_req.offset};
		end
		unique case (i_req.opcode)
			branch_ccr_pkg::UNCONDITIONAL_REL_JUMP_OP: dec.taken = 1'b1;
			branch_ccr_pkg::NEVER_TAKEN_REL_OP: dec.taken = 1'b0;
			branch_ccr_pkg::UNSIGNED_HIGHER_REL_OP: dec.taken = !(c | z);
			branch_ccr_pkg::UNSIGNED_LS_REL_OP: dec.taken = c | z;
			branch_ccr_pkg::CARRY_CLEAR_REL_OP: dec.taken = !c;
			branch_ccr_pkg::CARRY_SET_REL_OP: dec.taken = c;
			branch_ccr_pkg::NOT_EQUAL_REL_OP: dec.taken = !z;
			branch_ccr_pkg::EQUAL_REL_OP: dec.taken = z;
			branch_ccr_pkg::OVERFLOW_CLEAR_REL_OP: dec.taken = !v;
			branch_ccr_pkg::OVERFLOW_SET_REL_OP: dec.taken = v;
			branch_ccr_pkg::POSITIVE_REL_OP: dec.taken = !n;
			branch_ccr_pkg::NEGATIVE_REL_OP: dec.taken = n;
			branch_ccr_pkg::SIGNED_GE_REL_OP: dec.taken = !nxv;
			branch_ccr_pkg::SIGNED_LT_REL_OP: dec.taken = nxv;
			branch_ccr_pkg::SIGNED_GT_REL_OP: dec.taken = !(z | nxv);
			branch_ccr_pkg::SIGNED_LTE_REL_OP: dec.taken = z | nxv;
			branch_ccr_pkg::GOTO_INDEXED_OP: begin
				dec.kind = branch_ccr_pkg::KIND_GOTO;
				dec.cycles = branch_ccr_pkg::CYC_GOTO;
				dec.length = branch_ccr_pkg::LEN_TWO;
			end
			branch_ccr_pkg::GOTO_EXTENDED_OP: begin
				dec.kind = branch_ccr_pkg::KIND_GOTO;
				dec.cycles = branch_ccr_pkg::CYC_GOTO;
				dec.length = branch_ccr_pkg::LEN_THREE;
			end
			branch_ccr_pkg::CALL_DIRECT_OP: begin
				dec.kind = branch_ccr_pkg::KIND_CALL;
				dec.cycles = branch_ccr_pkg::CYC_CALL_DIRECT;
				dec.length = branch_ccr_pkg::LEN_TWO;
			end
			branch_ccr_pkg::CALL_INDEXED_OP: begin
				dec.kind = branch_ccr_pkg::KIND_CALL;
				dec.cycles = branch_ccr_pkg::CYC_CALL_OTHER;
				dec.length = branch_ccr_pkg::LEN_TWO;
			end
			branch_ccr_pkg::CALL_EXTENDED_OP: begin
				dec.kind = branch_ccr_pkg::KIND_CALL;
				dec.cycles = branch_ccr_pkg::CYC_CALL_OTHER;
				dec.length = branch_ccr_pkg::LEN_THREE;
			end
			branch_ccr_pkg::REL_CALL_OP: begin
				dec.kind = branch_ccr_pkg::KIND_REL_CALL;
				dec.cycles = branch_ccr_pkg::CYC_CALL_OTHER;
				dec.length = branch_ccr_pkg::LEN_TWO;
				dec.taken = 1'b1;
				dec.target = i_req.pc + 16'h0002 +
					{{8{i_req.offset[7]}}, i_req.offset};
			end
			branch_ccr_pkg::IRQ_RETURN_OP: begin
				dec.kind = branch_ccr_pkg::KIND_IRQ_RETURN;
				dec.cycles = branch_ccr_pkg::CYC_IRQ_RETURN;
				flags_next = i_req.stack_flags;
			end
			branch_ccr_pkg::SUB_RETURN_OP: begin
				dec.kind = branch_ccr_pkg::KIND_SUB_RETURN;
				dec.cycles = branch_ccr_pkg::CYC_SUB_RETURN;
			end
			branch_ccr_pkg::IDLE_OP: begin
				dec.kind = branch_ccr_pkg::KIND_IDLE;
			end
			branch_ccr_pkg::SOFT_TRAP_OP: begin
				dec.kind = branch_ccr_pkg::KIND_TRAP;
				dec.cycles = branch_ccr_pkg::CYC_TRAP;
				flags_next[branch_ccr_pkg::FLAG_I] = 1'b1;
			end
			branch_ccr_pkg::HALT_FOR_IRQ_OP: begin
				dec.kind = branch_ccr_pkg::KIND_HALT;
				dec.cycles = branch_ccr_pkg::CYC_HALT;
			end
			branch_ccr_pkg::CARRY_RESET_OP: begin
				dec.kind = branch_ccr_pkg::KIND_FLAG_OP;
				flags_next[branch_ccr_pkg::FLAG_C] = 1'b0;
			end
			branch_ccr_pkg::CARRY_FORCE_OP: begin
				dec.kind = branch_ccr_pkg::KIND_FLAG_OP;
				flags_next[branch_ccr_pkg::FLAG_C] = 1'b1;
			end
			branch_ccr_pkg::MASK_RESET_OP: begin
				dec.kind = branch_ccr_pkg::KIND_FLAG_OP;
				flags_next[branch_ccr_pkg::FLAG_I] = 1'b0;
			end
			branch_ccr_pkg::MASK_FORCE_OP: begin
				dec.kind = branch_ccr_pkg::KIND_FLAG_OP;
				flags_next[branch_ccr_pkg::FLAG_I] = 1'b1;
			end
			branch_ccr_pkg::OVERFLOW_RESET_OP: begin
				dec.kind = branch_ccr_pkg::KIND_FLAG_OP;
				flags_next[branch_ccr_pkg::FLAG_V] = 1'b0;
			end
			branch_ccr_pkg::OVERFLOW_FORCE_OP: begin
				dec.kind = branch_ccr_pkg::KIND_FLAG_OP;
				flags_next[branch_ccr_pkg::FLAG_V] = 1'b1;
			end
			branch_ccr_pkg::ACC_TO_FLAGS_OP: begin
				dec.kind = branch_ccr_pkg::KIND_FLAG_OP;
				flags_next = i_req.acc_a[5:0];
			end
			branch_ccr_pkg::FLAGS_TO_ACC_OP: begin
				dec.kind = branch_ccr_pkg::KIND_FLAGS_TO_ACC;
				dec.acc_write = 1'b1;
				dec.acc_data = {2'h3, flags_reg};
			end
			default: begin
				dec.legal = 1'b0;
			end
		endcase
	end

	assign o_ready = (state_reg == ST_IDLE);

	// one instruction at a time; done pulses on the last cycle of its count
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_reg <= ST_IDLE;
			count_reg <= 4'h0;
		end else begin
			unique case (state_reg)
				ST_IDLE: if (i_valid) begin
					state_reg <= ST_BUSY;
					count_reg <= dec.cycles - 4'h1;
				end
				ST_BUSY: begin
					count_reg <= count_reg - 4'h1;
					if (count_reg == 4'h1)
						state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_done <= 1'b0;
		else
			o_done <= (state_reg == ST_BUSY) && (count_reg == 4'h1);
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst)
			rsp_reg <= '0;
		else if (o_ready && i_valid)
			rsp_reg <= dec;
	end

	// branches and calls leave flags untouched
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst)
			flags_reg <= branch_ccr_pkg::FLAGS_RESET;
		else if (o_ready && i_valid)
			flags_reg <= flags_next;
	end

	assign o_rsp = rsp_reg;
	assign o_flags = flags_reg;

endmodule

// File: src/branch_ccr_pkg.sv
package branch_ccr_pkg;

	localparam int FLAG_H = 5;
	localparam int FLAG_I = 4;
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_V = 1;
	localparam int FLAG_C = 0;
	localparam logic [5:0] FLAGS_RESET = 6'h10;

	localparam logic [7:0] UNCONDITIONAL_REL_JUMP_OP = 8'h20;
	localparam logic [7:0] NEVER_TAKEN_REL_OP = 8'h21;
	localparam logic [7:0] UNSIGNED_HIGHER_REL_OP = 8'h22;
	localparam logic [7:0] UNSIGNED_LS_REL_OP = 8'h23;
	localparam logic [7:0] CARRY_CLEAR_REL_OP = 8'h24;
	localparam logic [7:0] UNSIGNED_HS_REL_OP = 8'h24;
	localparam logic [7:0] CARRY_SET_REL_OP = 8'h25;
	localparam logic [7:0] UNSIGNED_LOWER_REL_OP = 8'h25;
	localparam logic [7:0] NOT_EQUAL_REL_OP = 8'h26;
	localparam logic [7:0] EQUAL_REL_OP = 8'h27;
	localparam logic [7:0] OVERFLOW_CLEAR_REL_OP = 8'h28;
	localparam logic [7:0] OVERFLOW_SET_REL_OP = 8'h29;
	localparam logic [7:0] POSITIVE_REL_OP = 8'h2a;
	localparam logic [7:0] NEGATIVE_REL_OP = 8'h2b;
	localparam logic [7:0] SIGNED_GE_REL_OP = 8'h2c;
	localparam logic [7:0] SIGNED_LT_REL_OP = 8'h2d;
	localparam logic [7:0] SIGNED_GT_REL_OP = 8'h2e;
	localparam logic [7:0] SIGNED_LTE_REL_OP = 8'h2f;
	localparam logic [7:0] REL_CALL_OP = 8'h8d;
	localparam logic [7:0] GOTO_INDEXED_OP = 8'h6e;
	localparam logic [7:0] GOTO_EXTENDED_OP = 8'h7e;
	localparam logic [7:0] CALL_DIRECT_OP = 8'h9d;
	localparam logic [7:0] CALL_INDEXED_OP = 8'had;
	localparam logic [7:0] CALL_EXTENDED_OP = 8'hbd;
	localparam logic [7:0] IDLE_OP = 8'h01;
	localparam logic [7:0] IRQ_RETURN_OP = 8'h3b;
	localparam logic [7:0] SUB_RETURN_OP = 8'h39;
	localparam logic [7:0] SOFT_TRAP_OP = 8'h3f;
	localparam logic [7:0] HALT_FOR_IRQ_OP = 8'h3e;
	localparam logic [7:0] CARRY_RESET_OP = 8'h0c;
	localparam logic [7:0] CARRY_FORCE_OP = 8'h0d;
	localparam logic [7:0] MASK_RESET_OP = 8'h0e;
	localparam logic [7:0] MASK_FORCE_OP = 8'h0f;
	localparam logic [7:0] OVERFLOW_RESET_OP = 8'h0a;
	localparam logic [7:0] OVERFLOW_FORCE_OP = 8'h0b;
	localparam logic [7:0] ACC_TO_FLAGS_OP = 8'h06;
	localparam logic [7:0] FLAGS_TO_ACC_OP = 8'h07;

	localparam logic [3:0] CYC_BRANCH = 4'h3;
	localparam logic [3:0] CYC_GOTO = 4'h3;
	localparam logic [3:0] CYC_CALL_DIRECT = 4'h5;
	localparam logic [3:0] CYC_CALL_OTHER = 4'h6;
	localparam logic [3:0] CYC_IRQ_RETURN = 4'ha;
	localparam logic [3:0] CYC_SUB_RETURN = 4'h5;
	localparam logic [3:0] CYC_TRAP = 4'hc;
	localparam logic [3:0] CYC_HALT = 4'h9;
	localparam logic [3:0] CYC_SHORT = 4'h2;
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;

	typedef enum logic [3:0] {
		KIND_NONE = 4'h0,
		KIND_BRANCH = 4'h1,
		KIND_GOTO = 4'h2,
		KIND_CALL = 4'h3,
		KIND_REL_CALL = 4'h4,
		KIND_SUB_RETURN = 4'h5,
		KIND_IRQ_RETURN = 4'h6,
		KIND_TRAP = 4'h7,
		KIND_HALT = 4'h8,
		KIND_IDLE = 4'h9,
		KIND_FLAG_OP = 4'ha,
		KIND_FLAGS_TO_ACC = 4'hb
	} op_kind_e;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] offset;
		logic [15:0] pc;
		logic [7:0] acc_a;
		logic [5:0] stack_flags;
	} dec_req_s;

	typedef struct packed {
		op_kind_e kind;
		logic legal;
		logic taken;
		logic [15:0] target;
		logic [3:0] cycles;
		logic [1:0] length;
		logic acc_write;
		logic [7:0] acc_data;
	} dec_rsp_s;

endpackage

// File: sim/branch_ccr_asserts.sv
`timescale 1ns/10ps
module branch_ccr_asserts (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_valid,
	input wire branch_ccr_pkg::dec_req_s i_req,
	input wire logic o_ready,
	input wire logic o_done,
	input wire branch_ccr_pkg::dec_rsp_s o_rsp,
	input wire logic [5:0] o_flags
);
	wire go = i_valid && o_ready;
	wire [7:0] op = i_req.opcode;
	wire br = go && op[7:4] == 4'h2;
	wire z = o_flags[2];
	wire [15:0] tgt = i_req.pc + 16'h2 +
		{{8{i_req.offset[7]}}, i_req.offset};
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	chk_branch_three: assert property (br |-> ##3 o_done)
		else $error("branch length wrong");
	chk_flags_kept: assert property (br |=> o_flags == $past(o_flags))
		else $error("branch changed flags");
	chk_equal_test: assert property (go && op == 8'h27 |=>
		o_rsp.taken == $past(z))
		else $error("zero test wrong");
	chk_target_sum: assert property (br |=>
		!o_rsp.taken || o_rsp.target == $past(tgt))
		else $error("target wrong");
	chk_trap_mask: assert property (go && op == 8'h3f |=>
		o_flags[4] ##11 o_done)
		else $error("trap wrong");
	chk_halt_nine: assert property (go && op == 8'h3e |-> ##9 o_done)
		else $error("halt length wrong");
	chk_irq_restore: assert property (go && op == 8'h3b |=>
		o_flags == $past(i_req.stack_flags) ##9 o_done)
		else $error("restore wrong");
	chk_acc_copy: assert property (go && op == 8'h07 |=>
		o_rsp.acc_write && o_rsp.acc_data == {2'b11, $past(o_flags)})
		else $error("flag copy wrong");
	chk_call_six: assert property (go &&
		(op == 8'had || op == 8'hbd || op == 8'h8d) |=>
		!o_ready [*5] ##1 o_done)
		else $error("call length wrong");
	chk_goto_three: assert property (go &&
		(op == 8'h6e || op == 8'h7e) |-> ##3 o_done)
		else $error("goto length wrong");
	chk_short_two: assert property (go && op[7:4] == 4'h0 |->
		##2 o_done)
		else $error("flag op length wrong");
endmodule
bind branch_ccr_decoder branch_ccr_asserts branch_ccr_asserts_inst (
	.i_clock, .i_sys_rst, .i_valid, .i_req, .o_ready, .o_done, .o_rsp,
	.o_flags);

// File: sim/prog_mem_model.sv
`timescale 1ns/10ps
module prog_mem_model (
	input wire logic [15:0] i_addr,
	output logic [7:0] o_opcode,
	output logic [7:0] o_offset
);
	logic [7:0] mem [0:255];
	// opcode byte and the offset byte that follows it
	assign o_opcode = mem[i_addr[7:0]];
	assign o_offset = mem[i_addr[7:0] + 8'h1];
endmodule

// File: sim/branch_ccr_decoder_test.sv
`timescale 1ns/10ps
module branch_ccr_decoder_test;
	logic i_clock, i_sys_rst, i_valid, o_ready, o_done;
	branch_ccr_pkg::dec_req_s i_req;
	branch_ccr_pkg::dec_rsp_s o_rsp;
	logic [5:0] o_flags, mf;
	logic [15:0] pc;
	logic [7:0] f_op, f_off;
	integer n_mismatch = 0, n_compared = 0, seed = 32'h4235, i, k, r;
	logic [7:0] ops[$] = '{8'h01, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f,
		8'h06, 8'h07, 8'h39, 8'h3b, 8'h3e, 8'h3f, 8'h6e, 8'h7e, 8'h9d,
		8'had, 8'hbd, 8'h8d, 8'hff};
	branch_ccr_decoder branch_ccr_decoder_inst (.i_clock(i_clock),
		.i_sys_rst(i_sys_rst), .i_valid(i_valid), .i_req(i_req),
		.o_ready(o_ready), .o_done(o_done), .o_rsp(o_rsp), .o_flags(o_flags));
	prog_mem_model prog_mem_model_inst (.i_addr(pc), .o_opcode(f_op),
		.o_offset(f_off));
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	task automatic check(input logic [15:0] got, exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	function automatic logic cond(input logic [3:0] c, input logic [5:0] f);
		logic n, z, v, cy, t;
		{n, z, v, cy} = f[3:0];
		case (c[3:1])
		3'h0: t = 1'b1;
		3'h1: t = ~(cy | z);
		3'h2: t = ~cy;
		3'h3: t = ~z;
		3'h4: t = ~v;
		3'h5: t = ~n;
		3'h6: t = ~(n ^ v);
		default: t = ~(z | (n ^ v));
		endcase
		return t ^ c[0];
	endfunction
	function automatic int cyc(input logic [7:0] o);
		case (o)
		8'h9d, 8'h39: return 5;
		8'had, 8'hbd, 8'h8d: return 6;
		8'h3b: return 10;
		8'h3f: return 12;
		8'h3e: return 9;
		8'h6e, 8'h7e: return 3;
		default: return o[7:4] == 4'h2 ? 3 : 2;
		endcase
	endfunction
	function automatic int len(input logic [7:0] o);
		if (o == 8'h7e || o == 8'hbd) return 3;
		if (o[7:4] == 4'h2 || o == 8'h8d || o == 8'h6e || o == 8'h9d ||
			o == 8'had) return 2;
		return 1;
	endfunction
	task automatic run(input logic [7:0] op, off, acc, input logic [5:0] stk);
		logic [5:0] f;
		logic t;
		pc = 16'($random(seed));
		prog_mem_model_inst.mem[pc[7:0]] = op;
		prog_mem_model_inst.mem[pc[7:0] + 8'h1] = off;
		@(posedge i_clock);
		i_valid <= 1'b1;
		i_req <= '{f_op, f_off, pc, acc, stk};
		@(posedge i_clock);
		i_valid <= 1'b0;
		f = mf;
		t = cond(op[3:0], mf) || op == 8'h8d;
		case (op)
		8'h0a, 8'h0b: mf[1] = op[0];
		8'h0c, 8'h0d: mf[0] = op[0];
		8'h0e, 8'h0f: mf[4] = op[0];
		8'h06: mf = acc[5:0];
		8'h3b: mf = stk;
		8'h3f: mf[4] = 1'b1;
		default: ;
		endcase
		for (k = 1; k < 20; k++) begin
			@(posedge i_clock);
			#1;
			if (o_done === 1'b1) break;
		end
		// the taking edge is the first cycle of the count
		check(16'(k + 1), 16'(cyc(op)), "cycles");
		check(o_rsp.cycles, 16'(cyc(op)), "cycle field");
		check(o_flags, mf, "flags");
		check(o_rsp.legal, op != 8'hff, "legal");
		check(o_rsp.acc_write, op == 8'h07, "acc write");
		if (op != 8'hff) check(o_rsp.length, 16'(len(op)), "length");
		if (op[7:4] == 4'h2 || op == 8'h8d) begin
			check(o_rsp.taken, t, "taken");
			if (t) check(o_rsp.target,
				pc + 16'h2 + {{8{off[7]}}, off}, "target");
		end
		if (op == 8'h07) check(o_rsp.acc_data, {2'b11, f}, "copy");
	endtask
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clock);
		n_mismatch++;
		finish_test;
	end
	initial begin
		i_sys_rst = 1'b1;
		i_valid = 1'b0;
		i_req = '0;
		mf = 6'h10;
		pc = '0;
		repeat (10) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		#1 check(o_flags, 6'h10, "reset flags");
		foreach (ops[j]) run(ops[j], 8'($random(seed)),
			8'($random(seed)), 6'($random(seed)));
		$display("fixed opcodes done");
		for (i = 0; i < 300; i++) begin
			r = $random(seed);
			if (r[0]) run(8'h06, 8'h00, 8'($random(seed)), 6'h00);
			else run(8'h20 + r[4:1], 8'($random(seed)), 8'h00, 6'h00);
		end
		$display("random branches done");
		run(8'h06, 8'h00, 8'h00, 6'h00);
		@(posedge i_clock);
		i_req.opcode <= 8'h3e;
		i_valid <= 1'b1;
		@(posedge i_clock);
		i_valid <= 1'b0;
		#1 check(o_ready, 1'b0, "busy");
		@(posedge i_clock);
		i_sys_rst <= 1'b1;
		@(posedge i_clock);
		i_sys_rst <= 1'b0;
		mf = 6'h10;
		#1 check({o_ready, o_done, o_flags}, {2'b10, 6'h10}, "mid reset");
		run(8'h2b, 8'h80, 8'h00, 6'h00);
		$display("reset test done");
		finish_test;
	end
endmodule
